// file: tps_pkg.sv
/*
 * Shared constants and carrier types of the transmit one-step stamping block.
 * Assumes one clock (mclk, 10 MHz) and an APB register bus with 32-bit data.
 */
package tps_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int TPS_POS_W = 16;
    localparam int TPS_TAG_W = 16;
    localparam int TPS_LANE_W = 5;
    localparam int TPS_STAMP_W = 80;
    localparam int TPS_NS_W = 32;
    localparam int TPS_STEP_W = 16;
    localparam int TPS_ADDR_W = 8;
    localparam int TPS_DATA_W = 32;
    localparam int TPS_QUEUE_DEPTH = 8;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [TPS_ADDR_W-1:0] TPS_OFS_CTRL = 8'h00;
    localparam logic [TPS_ADDR_W-1:0] TPS_OFS_STATUS = 8'h04;
    localparam logic [TPS_ADDR_W-1:0] TPS_OFS_LANE_STEP = 8'h08;
    localparam logic [TPS_ADDR_W-1:0] TPS_OFS_ONE_CNT = 8'h0C;
    localparam logic [TPS_ADDR_W-1:0] TPS_OFS_TWO_CNT = 8'h10;
    localparam logic [TPS_ADDR_W-1:0] TPS_OFS_DROP_CNT = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TPS_CTRL_ENABLE_BIT = 0;
    localparam int TPS_CTRL_TRANSPARENT_BIT = 1;
    localparam int TPS_ST_WR_FAULT_BIT = 0;
    localparam int TPS_ST_RD_FAULT_BIT = 1;
    localparam int TPS_ST_ODD_POS_BIT = 2;
    localparam int TPS_ST_RANGE_BIT = 3;
    localparam int TPS_ST_LANE_COMP_BIT = 4;
    localparam int TPS_ST_LEVEL_LSB = 8;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [1:0] TPS_CTRL_RESET = 2'h1;
    localparam logic [TPS_STEP_W-1:0] TPS_LANE_STEP_RESET = 16'h0000;
    localparam logic [TPS_POS_W:0] TPS_TC_MARGIN = 17'h00022;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TPS_OP_NONE = 2'h0,
        TPS_OP_ONE_STEP = 2'h1,
        TPS_OP_TWO_STEP = 2'h2,
        TPS_OP_RESERVED = 2'h3
    } tps_op_t;

    typedef struct packed {
        tps_op_t op;
        logic chksum_refresh;
        logic [TPS_POS_W-1:0] chksum_byte_position;
        logic [TPS_POS_W-1:0] stamp_byte_position;
        logic [TPS_TAG_W-1:0] tag;
        logic [TPS_LANE_W-1:0] sop_lane;
        logic [TPS_STAMP_W-1:0] stamp;
    } tps_req_t;

    typedef struct packed {
        tps_op_t op;
        logic chksum_refresh;
        logic [TPS_POS_W-1:0] chksum_byte_position;
        logic [TPS_POS_W-1:0] stamp_byte_position;
        logic [TPS_TAG_W-1:0] tag;
        logic [TPS_LANE_W-1:0] sop_lane;
        logic [TPS_STAMP_W-1:0] stamp;
    } tps_desc_t;

endpackage : tps_pkg

// file: tps_queue.sv
/*
 * Tag queue: synchronous FIFO of WIDTH x DEPTH with a registered output stage.
 * Assumes DEPTH is a power of two; total capacity is exactly DEPTH words.
 */
`timescale 1ns/100ps
module tps_queue #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff, rd_ptr_ff;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic out_valid_ff, nxt_out_valid, in_ready_ff;
    logic [WIDTH-1:0] out_data_ff;
    wire push = in_valid & in_ready_ff;
    wire pop = out_valid_ff & out_ready;
    wire stage_free = ~out_valid_ff | pop;
    wire load = (cnt_ff != '0) & stage_free;
    // Skip the array when it is empty so the first word shows a cycle sooner
    wire bypass = push & (cnt_ff == '0) & stage_free;
    wire mem_write = push & ~bypass;

    assign nxt_cnt = cnt_ff + CNT_W'(mem_write) - CNT_W'(load);
    assign nxt_out_valid = (load | bypass) | (out_valid_ff & ~pop);

    always_ff @(posedge mclk) begin
        if (mem_write) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
            out_valid_ff <= 1'b0;
            out_data_ff <= '0;
            in_ready_ff <= 1'b0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + PTR_W'(mem_write);
            rd_ptr_ff <= rd_ptr_ff + PTR_W'(load);
            cnt_ff <= nxt_cnt;
            out_valid_ff <= nxt_out_valid;
            if (load) begin
                out_data_ff <= mem[rd_ptr_ff];
            end else if (bypass) begin
                out_data_ff <= in_data;
            end
            in_ready_ff <= ((nxt_cnt + CNT_W'(nxt_out_valid)) < CNT_W'(DEPTH));
        end
    end

    assign in_ready = in_ready_ff;
    assign out_valid = out_valid_ff;
    assign out_data = out_data_ff;
    assign level = cnt_ff + CNT_W'(out_valid_ff);

endmodule : tps_queue

// file: tps_lane_adjust.sv
/*
 * Lane skew correction of a transmit stamp: adds lane times step to the
 * nanoseconds field. Purely combinational; the caller registers the result.
 */
`timescale 1ns/100ps
module tps_lane_adjust #(
    parameter int STAMP_W = 80,
    parameter int NS_W = 32,
    parameter int LANE_W = 5,
    parameter int STEP_W = 16
) (
    input wire logic [STAMP_W-1:0] raw_stamp,
    input wire logic [LANE_W-1:0] sop_lane,
    input wire logic [STEP_W-1:0] lane_step,
    input wire logic apply,
    output logic [STAMP_W-1:0] adj_stamp
);
    localparam int PROD_W = LANE_W + STEP_W;

    // Nanoseconds carry into seconds is not handled; keep steps small
    wire [PROD_W-1:0] offset = PROD_W'(sop_lane) * PROD_W'(lane_step);
    wire [NS_W-1:0] ns_sum = raw_stamp[NS_W-1:0] + NS_W'(offset);

    assign adj_stamp = apply ? {raw_stamp[STAMP_W-1:NS_W], ns_sum} : raw_stamp;

endmodule : tps_lane_adjust

// file: tps_one_step_insert.sv
/*
 * Transmit one-step stamping control: qualifies per-frame stamping requests,
 * applies lane skew correction, queues descriptors for the insertion engine,
 * and reports tag queue faults. Registers over APB.
 * Assumes the client and the insertion engine run on mclk; the lane skew
 * setting may change at any time and is synchronised here.
 */
`timescale 1ns/100ps
module tps_one_step_insert #(
    parameter int QUEUE_DEPTH = tps_pkg::TPS_QUEUE_DEPTH
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tps_pkg::TPS_ADDR_W-1:0] paddr,
    input wire logic [tps_pkg::TPS_DATA_W-1:0] pwdata,
    output logic [tps_pkg::TPS_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_sop,
    input wire tps_pkg::tps_req_t frame_req,
    input wire logic [63:0] reserved_receive_stamp_input,
    input wire logic lane_skew_compensation,
    output logic req_ready,
    output logic desc_valid,
    output tps_pkg::tps_desc_t desc,
    input wire logic desc_take,
    output logic tag_write_fault,
    output logic tag_read_fault
);
    localparam int DESC_W = $bits(tps_pkg::tps_desc_t);
    localparam int LVL_W = $clog2(QUEUE_DEPTH+1);
    localparam int DW = tps_pkg::TPS_DATA_W;
    localparam int PW = tps_pkg::TPS_POS_W;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic [5:0] tps_decode(input logic [tps_pkg::TPS_ADDR_W-1:0] a);
        logic [5:0] hit;
        hit = 6'h00;
        hit[0] = (a == tps_pkg::TPS_OFS_CTRL);
        hit[1] = (a == tps_pkg::TPS_OFS_STATUS);
        hit[2] = (a == tps_pkg::TPS_OFS_LANE_STEP);
        hit[3] = (a == tps_pkg::TPS_OFS_ONE_CNT);
        hit[4] = (a == tps_pkg::TPS_OFS_TWO_CNT);
        hit[5] = (a == tps_pkg::TPS_OFS_DROP_CNT);
        return hit;
    endfunction : tps_decode

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [1:0] ctrl_ff;
    logic [tps_pkg::TPS_STEP_W-1:0] lane_step_ff;
    logic [DW-1:0] one_cnt_ff, two_cnt_ff, drop_cnt_ff;
    logic wr_fault_ff, rd_fault_ff, odd_pos_ff, range_ff;
    logic lane_meta_ff, lane_sync_ff;
    logic pready_ff, pslverr_ff;
    logic [DW-1:0] prdata_ff;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // Answer in the second access cycle, so read data comes from a flop
    wire [5:0] hit = tps_decode(paddr);
    wire mapped = |hit;
    wire access = psel & penable;
    wire answer_now = access & ~pready_ff;
    wire wr_commit = access & pready_ff & pwrite & mapped;
    wire wr_ctrl = wr_commit & hit[0];
    wire wr_status = wr_commit & hit[1];
    wire wr_step = wr_commit & hit[2];
    wire clr_one = wr_commit & hit[3];
    wire clr_two = wr_commit & hit[4];
    wire clr_drop = wr_commit & hit[5];

    wire enable = ctrl_ff[tps_pkg::TPS_CTRL_ENABLE_BIT];
    wire transparent = ctrl_ff[tps_pkg::TPS_CTRL_TRANSPARENT_BIT];

    // ------------------------------------------------------------
    // Frame request qualification
    // ------------------------------------------------------------
    wire [LVL_W-1:0] level;
    wire queue_ready;
    wire tps_pkg::tps_desc_t q_out;
    wire [tps_pkg::TPS_STAMP_W-1:0] adj_stamp;
    tps_pkg::tps_desc_t new_desc;

    wire op_one = (frame_req.op == tps_pkg::TPS_OP_ONE_STEP);
    wire op_two = (frame_req.op == tps_pkg::TPS_OP_TWO_STEP);
    wire take_req = frame_sop & enable;
    // Reserved codes are treated like no-op and never reach the queue
    wire queue_req = take_req & (op_one | op_two);
    wire push = queue_req & queue_ready;
    wire use_chksum = op_one & frame_req.chksum_refresh;
    wire apply_adjust = op_one & lane_sync_ff;

    wire [PW:0] chk_limit = {1'b0, frame_req.chksum_byte_position} + tps_pkg::TPS_TC_MARGIN;
    wire range_bad = ({1'b0, frame_req.stamp_byte_position} > chk_limit);
    wire range_set = queue_req & use_chksum & transparent & range_bad;
    wire odd_stamp = op_one & frame_req.stamp_byte_position[0];
    wire odd_chk = use_chksum & frame_req.chksum_byte_position[0];
    wire odd_set = queue_req & (odd_stamp | odd_chk);

    // Lost descriptor: the queue was full when a stamped frame started
    wire wr_fault_set = queue_req & ~queue_ready;
    // Engine took a descriptor that was never there
    wire rd_fault_set = desc_take & ~desc_valid;

    tps_lane_adjust #(
        .STAMP_W(tps_pkg::TPS_STAMP_W),
        .NS_W(tps_pkg::TPS_NS_W),
        .LANE_W(tps_pkg::TPS_LANE_W),
        .STEP_W(tps_pkg::TPS_STEP_W)
    ) u_adjust (
        .raw_stamp(frame_req.stamp),
        .sop_lane(frame_req.sop_lane),
        .lane_step(lane_step_ff),
        .apply(apply_adjust),
        .adj_stamp(adj_stamp)
    );

    always_comb begin
        new_desc = '0;
        new_desc.op = frame_req.op;
        new_desc.tag = frame_req.tag;
        new_desc.sop_lane = frame_req.sop_lane;
        new_desc.stamp = adj_stamp;
        new_desc.chksum_refresh = use_chksum;
        if (use_chksum) begin
            new_desc.chksum_byte_position = frame_req.chksum_byte_position;
        end
        // One position serves both the stamp and the correction field
        if (op_one) begin
            new_desc.stamp_byte_position = frame_req.stamp_byte_position;
        end
    end

    tps_queue #(
        .WIDTH(DESC_W),
        .DEPTH(QUEUE_DEPTH)
    ) u_queue (
        .mclk(mclk),
        .reset_n(reset_n),
        .in_valid(push),
        .in_data(new_desc),
        .in_ready(queue_ready),
        .out_valid(desc_valid),
        .out_data(q_out),
        .out_ready(desc_take),
        .level(level)
    );

    assign desc = q_out;
    assign req_ready = queue_ready;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [DW-1:0] status_word;
    logic [DW-1:0] rd_word;

    always_comb begin
        status_word = '0;
        status_word[tps_pkg::TPS_ST_WR_FAULT_BIT] = wr_fault_ff;
        status_word[tps_pkg::TPS_ST_RD_FAULT_BIT] = rd_fault_ff;
        status_word[tps_pkg::TPS_ST_ODD_POS_BIT] = odd_pos_ff;
        status_word[tps_pkg::TPS_ST_RANGE_BIT] = range_ff;
        status_word[tps_pkg::TPS_ST_LANE_COMP_BIT] = lane_sync_ff;
        status_word[tps_pkg::TPS_ST_LEVEL_LSB +: LVL_W] = level;
    end

    always_comb begin
        rd_word = '0;
        unique case (1'b1)
            hit[0]: rd_word = DW'(ctrl_ff);
            hit[1]: rd_word = status_word;
            hit[2]: rd_word = DW'(lane_step_ff);
            hit[3]: rd_word = one_cnt_ff;
            hit[4]: rd_word = two_cnt_ff;
            hit[5]: rd_word = drop_cnt_ff;
            default: rd_word = '0;
        endcase
    end

    // ------------------------------------------------------------
    // Bus answer registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            pready_ff <= answer_now;
            pslverr_ff <= answer_now & ~mapped;
            if (answer_now && !pwrite) begin
                prdata_ff <= rd_word;
            end
        end
    end

    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ctrl_ff <= tps_pkg::TPS_CTRL_RESET;
            lane_step_ff <= tps_pkg::TPS_LANE_STEP_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= pwdata[1:0];
            end
            if (wr_step) begin
                lane_step_ff <= pwdata[tps_pkg::TPS_STEP_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Lane skew setting synchroniser
    // ------------------------------------------------------------
    // The setting is quasi-static and may come from another domain
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            lane_meta_ff <= 1'b0;
            lane_sync_ff <= 1'b0;
        end else begin
            lane_meta_ff <= lane_skew_compensation;
            lane_sync_ff <= lane_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Faults ignore software writes on purpose: only a path reset clears them
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wr_fault_ff <= 1'b0;
            rd_fault_ff <= 1'b0;
            odd_pos_ff <= 1'b0;
            range_ff <= 1'b0;
        end else begin
            wr_fault_ff <= wr_fault_ff | wr_fault_set;
            rd_fault_ff <= rd_fault_ff | rd_fault_set;
            odd_pos_ff <= (odd_pos_ff & ~(wr_status & pwdata[tps_pkg::TPS_ST_ODD_POS_BIT]))
                | odd_set;
            range_ff <= (range_ff & ~(wr_status & pwdata[tps_pkg::TPS_ST_RANGE_BIT]))
                | range_set;
        end
    end

    assign tag_write_fault = wr_fault_ff;
    assign tag_read_fault = rd_fault_ff;

    // ------------------------------------------------------------
    // Frame counters
    // ------------------------------------------------------------
    // A count in the clearing cycle is kept so no frame goes missing
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            one_cnt_ff <= '0;
            two_cnt_ff <= '0;
            drop_cnt_ff <= '0;
        end else begin
            one_cnt_ff <= (clr_one ? '0 : one_cnt_ff) + DW'(push & op_one);
            two_cnt_ff <= (clr_two ? '0 : two_cnt_ff) + DW'(push & op_two);
            drop_cnt_ff <= (clr_drop ? '0 : drop_cnt_ff) + DW'(wr_fault_set);
        end
    end

endmodule : tps_one_step_insert

// file: tps_one_step_insert_assertions.sv
/*
 * Port checker of the transmit stamping block, bound to its top module.
 * Assumes software keeps the enable bit of CTRL set while frames are sent.
 */
`timescale 1ns/100ps
module tps_one_step_insert_assertions (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic frame_sop,
    input wire tps_pkg::tps_req_t frame_req,
    input wire logic req_ready,
    input wire logic desc_valid,
    input wire tps_pkg::tps_desc_t desc,
    input wire logic desc_take,
    input wire logic tag_write_fault,
    input wire logic tag_read_fault
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    sequence s_req;
        frame_sop && req_ready && !desc_valid && (frame_req.op == tps_pkg::TPS_OP_ONE_STEP
            || frame_req.op == tps_pkg::TPS_OP_TWO_STEP);
    endsequence
    sequence s_desc;
        desc_valid && desc.tag == $past(frame_req.tag) && desc.op == $past(frame_req.op);
    endsequence
    property p_sop_desc;
        s_req |=> s_desc;
    endproperty
    a_sop_desc: assert property (p_sop_desc) else $error("request not queued");
    property p_chk_unused;
        desc_valid && !desc.chksum_refresh |-> desc.chksum_byte_position == 16'h0000;
    endproperty
    a_chk_unused: assert property (p_chk_unused) else $error("checksum position kept");
    property p_refresh_one;
        desc_valid && desc.op != tps_pkg::TPS_OP_ONE_STEP |-> !desc.chksum_refresh;
    endproperty
    a_refresh_one: assert property (p_refresh_one) else $error("refresh off one-step");
    property p_stamp_unused;
        desc_valid && desc.op != tps_pkg::TPS_OP_ONE_STEP |-> desc.stamp_byte_position == 16'h0000;
    endproperty
    a_stamp_unused: assert property (p_stamp_unused) else $error("stamp position kept");

    property p_take_fault;
        desc_take && !desc_valid |=> tag_read_fault;
    endproperty
    a_take_fault: assert property (p_take_fault) else $error("read fault missing");
    property p_rd_cause;
        $rose(tag_read_fault) |-> $past(desc_take && !desc_valid);
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("read fault without cause");
    property p_rd_hold;
        tag_read_fault |=> tag_read_fault;
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read fault cleared");
    property p_wr_cause;
        $rose(tag_write_fault) |-> $past(frame_sop && !req_ready);
    endproperty
    a_wr_cause: assert property (p_wr_cause) else $error("write fault without cause");
    property p_wr_hold;
        tag_write_fault |=> tag_write_fault;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write fault cleared");

    property p_apb;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("bus answer wrong");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without answer");
endmodule : tps_one_step_insert_assertions

bind tps_one_step_insert tps_one_step_insert_assertions u_chk (.*);

// file: tps_client_model.sv
/*
 * Client model: issues one frame request per go and takes descriptors.
 * Assumes it runs on the block's mclk.
 */
`timescale 1ns/100ps
module tps_client_model (
    input wire logic mclk,
    input wire logic go,
    input wire tps_pkg::tps_req_t req_in,
    input wire logic take_en,
    input wire logic force_take,
    input wire logic desc_valid,
    input wire tps_pkg::tps_desc_t desc,
    output logic frame_sop,
    output tps_pkg::tps_req_t frame_req,
    output logic [63:0] reserved_receive_stamp_input,
    output logic desc_take,
    output tps_pkg::tps_desc_t last_desc,
    output int taken
);
    assign reserved_receive_stamp_input = 64'h0;
    assign desc_take = force_take | (take_en & desc_valid);
    // Controls toggle between frames, so a stale sample never looks valid
    always @(posedge mclk) begin
        frame_sop <= go;
        frame_req <= go ? req_in : tps_pkg::tps_req_t'(~frame_req);
        if (desc_take && desc_valid) begin
            last_desc <= desc;
            taken <= taken + 1;
        end
    end
endmodule : tps_client_model

// file: tps_one_step_insert_test.sv
/*
 * Self-checking bench of the stamping block with a client model.
 * Assumes mclk at 10 MHz and an APB master with one word per register.
 */
`timescale 1ns/100ps
module tps_one_step_insert_test;
    logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [tps_pkg::TPS_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic go, take_en, force_take, lane_skew_compensation, frame_sop, req_ready;
    logic desc_valid, desc_take, tag_write_fault, tag_read_fault;
    logic [63:0] reserved_receive_stamp_input;
    tps_pkg::tps_req_t req_in, frame_req, r;
    tps_pkg::tps_desc_t desc, last_desc, e;
    int taken, fail_count, cmp_count;

    tps_one_step_insert dut (.*);
    tps_client_model client (.*);

    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic check_w(input string n, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask : check_w

    task automatic check_d(input tps_pkg::tps_desc_t x, input tps_pkg::tps_desc_t g);
        cmp_count++;
        if (g !== x) begin
            fail_count++;
            $display("CHECK FAILED desc expected %h seen %h", x, g);
        end
    endtask : check_d

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Sends r; when q is set waits for its descriptor and compares it with e
    task automatic send(input logic q);
        int n0;
        int n;
        n0 = taken;
        @(posedge mclk);
        go <= 1'h1;
        req_in <= r;
        @(posedge mclk);
        go <= 1'h0;
        n = 0;
        while (q && taken == n0 && n < 10) begin
            @(posedge mclk);
            n++;
        end
        if (q && n >= 10) begin
            fail_count++;
            results();
        end
        repeat (3) @(posedge mclk);
        if (q) begin
            check_d(e, last_desc);
        end
    endtask : send

    task automatic t_reset;
        apb(1'h0, tps_pkg::TPS_OFS_CTRL, 32'h0);
        check_w("ctrl", 32'h1, rd);
        apb(1'h0, tps_pkg::TPS_OFS_LANE_STEP, 32'h0);
        check_w("step", 32'h0, rd);
        apb(1'h0, 8'h40, 32'h0);
        check_w("unmapped", 32'h1, err);
        $display("test reset done");
    endtask : t_reset

    task automatic t_ops;
        int n0;
        for (int i = 0; i < 5; i++) begin
            r = '{tps_pkg::tps_op_t'(i[1:0]), i != 4, 16'h0020, 16'h002C, 16'(i), 5'h3, 80'h5};
            e = r;
            if (i == 4) begin
                e.op = tps_pkg::TPS_OP_ONE_STEP;
                r.op = tps_pkg::TPS_OP_ONE_STEP;
                e.chksum_byte_position = 16'h0000;
            end else if (i != 1) begin
                e.chksum_refresh = 1'h0;
                e.chksum_byte_position = 16'h0000;
                e.stamp_byte_position = 16'h0000;
            end
            n0 = taken;
            send(i == 1 || i == 2 || i == 4);
            check_w("taken", n0 + ((i == 0 || i == 3) ? 0 : 1), taken);
        end
        apb(1'h0, tps_pkg::TPS_OFS_ONE_CNT, 32'h0);
        check_w("one_cnt", 32'h2, rd);
        apb(1'h0, tps_pkg::TPS_OFS_TWO_CNT, 32'h0);
        check_w("two_cnt", 32'h1, rd);
        apb(1'h1, tps_pkg::TPS_OFS_ONE_CNT, 32'h0);
        apb(1'h0, tps_pkg::TPS_OFS_ONE_CNT, 32'h0);
        check_w("one_clr", 32'h0, rd);
        $display("test ops done");
    endtask : t_ops

    task automatic t_lane;
        apb(1'h1, tps_pkg::TPS_OFS_LANE_STEP, 32'h3);
        lane_skew_compensation <= 1'h1;
        repeat (3) @(posedge mclk);
        r = '{tps_pkg::TPS_OP_ONE_STEP, 1'h0, 16'h0, 16'h0030, 16'h7, 5'h4, 80'h1_FFFF_FFF8};
        e = r;
        e.stamp[31:0] = 32'h0000_0004;
        send(1'h1);
        r.op = tps_pkg::TPS_OP_TWO_STEP;
        e = r;
        e.stamp_byte_position = 16'h0000;
        send(1'h1);
        lane_skew_compensation <= 1'h0;
        repeat (3) @(posedge mclk);
        r.op = tps_pkg::TPS_OP_ONE_STEP;
        e = r;
        send(1'h1);
        $display("test lane done");
    endtask : t_lane

    task automatic t_pos;
        apb(1'h1, tps_pkg::TPS_OFS_CTRL, 32'h3);
        r = '{tps_pkg::TPS_OP_ONE_STEP, 1'h1, 16'h0010, 16'h0035, 16'h9, 5'h0, 80'h0};
        e = r;
        send(1'h1);
        apb(1'h0, tps_pkg::TPS_OFS_STATUS, 32'h0);
        check_w("status_pos", 32'hC, rd & 32'hC);
        apb(1'h1, tps_pkg::TPS_OFS_STATUS, 32'hF);
        apb(1'h0, tps_pkg::TPS_OFS_STATUS, 32'h0);
        check_w("status_clr", 32'h0, rd & 32'hF);
        $display("test pos done");
    endtask : t_pos

    task automatic t_full;
        int n;
        take_en <= 1'h0;
        r = '{tps_pkg::TPS_OP_TWO_STEP, 1'h0, 16'h0, 16'h0, 16'h0, 5'h0, 80'h0};
        for (int i = 0; i < 9; i++) begin
            if (i == 8) begin
                check_w("req_ready", 32'h0, req_ready);
            end
            send(1'h0);
        end
        check_w("wr_fault", 32'h1, tag_write_fault);
        apb(1'h0, tps_pkg::TPS_OFS_STATUS, 32'h0);
        check_w("level", 32'h801, rd & 32'hF03);
        apb(1'h0, tps_pkg::TPS_OFS_DROP_CNT, 32'h0);
        check_w("drop_cnt", 32'h1, rd);
        n = taken;
        take_en <= 1'h1;
        repeat (12) @(posedge mclk);
        check_w("drained", n + 8, taken);
        check_w("empty", 32'h0, desc_valid);
        $display("test full done");
    endtask : t_full

    task automatic t_fault;
        force_take <= 1'h1;
        @(posedge mclk);
        force_take <= 1'h0;
        repeat (3) @(posedge mclk);
        check_w("rd_fault", 32'h1, tag_read_fault);
        reset_n <= 1'h0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'h1;
        repeat (2) @(posedge mclk);
        check_w("faults_clr", 32'h0, {tag_write_fault, tag_read_fault});
        $display("test fault done");
    endtask : t_fault

    initial begin
        {reset_n, psel, penable, pwrite, go, force_take, lane_skew_compensation} = '0;
        take_en = 1'h1;
        paddr = '0;
        pwdata = 32'h0;
        req_in = '0;
        fail_count = 0;
        cmp_count = 0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'h1;
        repeat (2) @(posedge mclk);
        t_reset();
        t_ops();
        t_lane();
        t_pos();
        t_full();
        t_fault();
        results();
    end
endmodule : tps_one_step_insert_test
